// *** hw/pms_pkg.sv ***
// Purpose: Shared constants and types for the power mode and reset supervisor.
// Assumes: One 20 MHz clock; supply levels arrive as digital comparator codes.
// Notes: Every offset, field position, timing count and multi-bit reset value lives here.

package pms_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  // Least time a generated internal reset is held; rounded up to whole cycles.
  localparam int RESET_HOLD_NS = 200;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 3;

  // ==========================================================================
  // Reset reason flags
  localparam int RSN_W = 6;
  localparam int RSN_PIN = 0;
  localparam int RSN_WATCHDOG = 1;
  localparam int RSN_SOFT = 2;
  localparam int RSN_WAKE_OFF = 3;
  localparam int RSN_BROWNOUT = 4;
  localparam int RSN_POWER_ON = 5;
  localparam logic [RSN_W-1:0] RSN_RESET_VALUE = 6'h20;
  localparam logic [RSN_W-1:0] RSN_BROWNOUT_VALUE = 6'h10;

  // ==========================================================================
  // Supply-fail comparator configuration
  localparam int THR_W = 4;
  localparam logic [THR_W-1:0] THR_RESET_VALUE = 4'h0;

  // ==========================================================================
  // Reset pin selection
  localparam int PIN_SEL_W = 5;
  localparam int NUM_PINS = 32;
  localparam logic [PIN_SEL_W-1:0] PIN_SEL_RESET_VALUE = 5'h00;

  // ==========================================================================
  // RAM section power control
  localparam int RAM_SECTIONS = 3;
  localparam int RAM_SEL_W = 2;
  localparam int RAM_FIELD_W = 2;
  localparam int RAM_POWER_BIT = 0;
  localparam int RAM_RETENTION_BIT = 1;
  localparam logic [RAM_FIELD_W-1:0] RAM_RESET_VALUE = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    PMS_POR,
    PMS_ON,
    PMS_OFF,
    PMS_EMU_OFF,
    PMS_RESET
  } pms_state_t;

  typedef enum logic {
    PMS_SUB_LOW_POWER,
    PMS_SUB_FIXED
  } pms_sub_t;

  // Returns {accessible, retained} for one RAM section.
  function automatic logic [1:0] pms_ram_status(input logic sys_off, input logic [RAM_FIELD_W-1:0] field);
    logic pwr;
    logic ret;
    pwr = field[RAM_POWER_BIT];
    ret = field[RAM_RETENTION_BIT];
    if (sys_off) begin
      pms_ram_status = {1'b0, ret};
    end else begin
      pms_ram_status = {pwr, pwr | ret};
    end
  endfunction

endpackage

// *** hw/pms_supervisor.sv ***
// Purpose: Power mode, regulator, RAM power and reset-source supervisor.
// Assumes: Software accesses arrive as one-cycle write strobes with data.
// Notes: rst_n is the power-on reset; the internal resets leave retained state.
//
// How it works
// - LDO after reset; switcher only when enabled.
// - Off request powers down, terminates tasks.
// - Off wakes only on detect or reset.
// - Wakeup goes through reset, recorded as wakeup.
// - Debug mode only emulates off, resources kept.
// - Debug-mode wakeup leaves debug port unreset.
// - Reset reason flags accumulate until cleared; brownout overwrites.
// - Sub mode applies only when all idle.
// - Fixed-latency task selects fixed-latency sub mode.
// - Low-power task selects low-power sub mode.
// - Every System ON entry starts low-power.
// - Enabled comparator warns when supply below threshold.
// - Warning also fires at enable when below.
// - Below threshold blocks flash writes.
// - Comparator inactive in off or clock stopped.
// - Off: retained per retention field, never accessible.
// - On: power on accessible; off retained if retention.
// - RAM power registers survive off and internal resets.
// - Hold reset until supply and regulators ready.
// - Selected reset pin generates pin reset.
// - Core request or access-port write: soft reset.
// - Watchdog timeout generates watchdog reset.
// - Brownout holds system in reset.

`timescale 1ns/1ps

module pms_supervisor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Regulator control
  input wire logic switcher_enable_wr,
  input wire logic switcher_enable_wdata,
  output logic switcher_enable_reg,
  // System off and sub power mode control
  input wire logic deep_off_request_wr,
  input wire logic deep_off_request_wdata,
  input wire logic fixed_latency_task,
  input wire logic low_power_task,
  // Supply-fail comparator configuration
  input wire logic supply_fail_config_wr,
  input wire logic supply_fail_config_enable,
  input wire logic [pms_pkg::THR_W-1:0] supply_fail_config_threshold,
  output logic supply_fail_config_enable_reg,
  output logic [pms_pkg::THR_W-1:0] supply_fail_threshold,
  // Reset reason, write one to clear
  input wire logic reset_reason_clear_wr,
  input wire logic [pms_pkg::RSN_W-1:0] reset_reason_clear_mask,
  output logic [pms_pkg::RSN_W-1:0] reset_reason_reg,
  // Reset pin selection
  input wire logic reset_pin_select_wr,
  input wire logic [pms_pkg::PIN_SEL_W-1:0] reset_pin_select_wdata,
  input wire logic reset_pin_select_connect,
  output logic [pms_pkg::PIN_SEL_W-1:0] reset_pin_select_reg,
  output logic reset_pin_connected,
  // RAM section power registers
  input wire logic ram_power_wr,
  input wire logic [pms_pkg::RAM_SEL_W-1:0] ram_power_sel,
  input wire logic [pms_pkg::RAM_FIELD_W-1:0] ram_power_wdata,
  output logic [pms_pkg::RAM_SECTIONS*pms_pkg::RAM_FIELD_W-1:0] ram_power_reg,
  // System status inputs
  input wire logic debug_mode,
  input wire logic pin_detect,
  input wire logic cpu_idle,
  input wire logic periph_idle,
  input wire logic fast_clock_running,
  input wire logic [pms_pkg::THR_W-1:0] supply_level,
  input wire logic supply_valid,
  input wire logic regulators_started,
  input wire logic brownout_below,
  // Reset sources
  input wire logic [pms_pkg::NUM_PINS-1:0] gpio_in,
  input wire logic core_reset_request_bit,
  input wire logic control_access_port_reset_wr,
  input wire logic watchdog_timeout,
  // Power and reset outputs
  output logic regulator_switcher_sel,
  output logic system_reset,
  output logic debug_access_port_reset,
  output logic core_power_down,
  output logic tasks_terminate,
  output logic emulated_off,
  output logic fixed_latency_active,
  output logic low_power_active,
  output logic supply_fail_warning_event,
  output logic flash_write_block,
  output logic [pms_pkg::RAM_SECTIONS-1:0] ram_accessible,
  output logic [pms_pkg::RAM_SECTIONS-1:0] ram_retained
);

  // ==========================================================================
  // Sequencer state
  pms_pkg::pms_state_t state;
  pms_pkg::pms_state_t next_state;
  pms_pkg::pms_sub_t sub_mode;
  pms_pkg::pms_sub_t next_sub_mode;
  logic [pms_pkg::HOLD_CNT_W-1:0] hold_cnt;
  logic [pms_pkg::HOLD_CNT_W-1:0] next_hold_cnt;
  logic keep_debug;
  logic next_keep_debug;
  logic [pms_pkg::RSN_W-1:0] next_reset_reason_reg;

  logic pin_asserted;
  logic soft_req;
  logic off_req;
  logic [pms_pkg::RSN_W-1:0] rsn_set;
  logic any_reset_src;

  always_comb begin
    // Reset pin is active low and only counts once connected.
    pin_asserted = reset_pin_connected && !gpio_in[reset_pin_select_reg];
    soft_req = core_reset_request_bit || control_access_port_reset_wr;
    off_req = deep_off_request_wr && deep_off_request_wdata;
    rsn_set = '0;
    next_state = state;
    next_sub_mode = sub_mode;
    next_hold_cnt = hold_cnt;
    next_keep_debug = keep_debug;
    case (state)
      pms_pkg::PMS_POR: begin
        if (supply_valid && regulators_started && !brownout_below) begin
          next_state = pms_pkg::PMS_ON;
          next_sub_mode = pms_pkg::PMS_SUB_LOW_POWER;
        end
      end
      pms_pkg::PMS_ON, pms_pkg::PMS_EMU_OFF: begin
        rsn_set[pms_pkg::RSN_PIN] = pin_asserted;
        rsn_set[pms_pkg::RSN_WATCHDOG] = watchdog_timeout;
        rsn_set[pms_pkg::RSN_SOFT] = soft_req;
        if (state == pms_pkg::PMS_EMU_OFF && pin_detect) begin
          rsn_set[pms_pkg::RSN_WAKE_OFF] = 1'b1;
          next_keep_debug = 1'b1;
        end
        if (fixed_latency_task) begin
          next_sub_mode = pms_pkg::PMS_SUB_FIXED;
        end else if (low_power_task) begin
          next_sub_mode = pms_pkg::PMS_SUB_LOW_POWER;
        end
        if (rsn_set != '0) begin
          next_state = pms_pkg::PMS_RESET;
          next_hold_cnt = pms_pkg::HOLD_CNT_W'(pms_pkg::RESET_HOLD_CYCLES - 1);
        end else if (state == pms_pkg::PMS_ON && off_req) begin
          // Debug sessions lose nothing: the off state is only emulated.
          next_state = debug_mode ? pms_pkg::PMS_EMU_OFF : pms_pkg::PMS_OFF;
        end
      end
      pms_pkg::PMS_OFF: begin
        // The watchdog is stopped here, so only the pin and detect wake it.
        rsn_set[pms_pkg::RSN_PIN] = pin_asserted;
        rsn_set[pms_pkg::RSN_WAKE_OFF] = pin_detect && !pin_asserted;
        if (rsn_set != '0) begin
          next_state = pms_pkg::PMS_RESET;
          next_hold_cnt = pms_pkg::HOLD_CNT_W'(pms_pkg::RESET_HOLD_CYCLES - 1);
          next_keep_debug = debug_mode;
        end
      end
      pms_pkg::PMS_RESET: begin
        // A pin still held low stretches the reset.
        if (pin_asserted) begin
          next_hold_cnt = pms_pkg::HOLD_CNT_W'(pms_pkg::RESET_HOLD_CYCLES - 1);
        end else if (hold_cnt != '0) begin
          next_hold_cnt = hold_cnt - 1'b1;
        end else begin
          next_state = pms_pkg::PMS_ON;
          next_sub_mode = pms_pkg::PMS_SUB_LOW_POWER;
          next_keep_debug = 1'b0;
        end
      end
      default: begin
        next_state = pms_pkg::PMS_POR;
      end
    endcase
    // Set wins over a clear in the same cycle.
    next_reset_reason_reg = reset_reason_reg;
    if (reset_reason_clear_wr) begin
      next_reset_reason_reg = next_reset_reason_reg & ~reset_reason_clear_mask;
    end
    next_reset_reason_reg = next_reset_reason_reg | rsn_set;
    if (brownout_below) begin
      next_state = pms_pkg::PMS_POR;
      next_keep_debug = 1'b0;
      next_reset_reason_reg = pms_pkg::RSN_BROWNOUT_VALUE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pms_pkg::PMS_POR;
      sub_mode <= pms_pkg::PMS_SUB_LOW_POWER;
      hold_cnt <= '0;
      keep_debug <= 1'b0;
      reset_reason_reg <= pms_pkg::RSN_RESET_VALUE;
    end else if (clk_en) begin
      state <= next_state;
      sub_mode <= next_sub_mode;
      hold_cnt <= next_hold_cnt;
      keep_debug <= next_keep_debug;
      reset_reason_reg <= next_reset_reason_reg;
    end
  end

  // ==========================================================================
  // Configuration registers
  logic next_switcher_enable_reg;
  logic next_cfg_enable;
  logic [pms_pkg::THR_W-1:0] next_threshold;
  logic [pms_pkg::PIN_SEL_W-1:0] next_pin_sel;
  logic next_pin_connected;
  logic [pms_pkg::RAM_SECTIONS*pms_pkg::RAM_FIELD_W-1:0] next_ram_power_reg;

  always_comb begin
    next_switcher_enable_reg = switcher_enable_reg;
    next_cfg_enable = supply_fail_config_enable_reg;
    next_threshold = supply_fail_threshold;
    next_pin_sel = reset_pin_select_reg;
    next_pin_connected = reset_pin_connected;
    next_ram_power_reg = ram_power_reg;
    if (system_reset) begin
      // Ordinary registers return to defaults; pin select and RAM power are kept.
      next_switcher_enable_reg = 1'b0;
      next_cfg_enable = 1'b0;
      next_threshold = pms_pkg::THR_RESET_VALUE;
    end else begin
      if (switcher_enable_wr) begin
        next_switcher_enable_reg = switcher_enable_wdata;
      end
      if (supply_fail_config_wr) begin
        next_cfg_enable = supply_fail_config_enable;
        next_threshold = supply_fail_config_threshold;
      end
      if (reset_pin_select_wr) begin
        next_pin_sel = reset_pin_select_wdata;
        next_pin_connected = reset_pin_select_connect;
      end
      // Writes to an unused section index are ignored.
      if (ram_power_wr && (ram_power_sel < pms_pkg::RAM_SEL_W'(pms_pkg::RAM_SECTIONS))) begin
        next_ram_power_reg[ram_power_sel*pms_pkg::RAM_FIELD_W +: pms_pkg::RAM_FIELD_W] = ram_power_wdata;
      end
    end
  end

  // Pin select and RAM power reset only with power-on, so they survive off and internal resets.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      switcher_enable_reg <= 1'b0;
      supply_fail_config_enable_reg <= 1'b0;
      supply_fail_threshold <= pms_pkg::THR_RESET_VALUE;
      reset_pin_select_reg <= pms_pkg::PIN_SEL_RESET_VALUE;
      reset_pin_connected <= 1'b0;
      ram_power_reg <= {pms_pkg::RAM_SECTIONS{pms_pkg::RAM_RESET_VALUE}};
    end else if (clk_en) begin
      switcher_enable_reg <= next_switcher_enable_reg;
      supply_fail_config_enable_reg <= next_cfg_enable;
      supply_fail_threshold <= next_threshold;
      reset_pin_select_reg <= next_pin_sel;
      reset_pin_connected <= next_pin_connected;
      ram_power_reg <= next_ram_power_reg;
    end
  end

  // ==========================================================================
  // Derived outputs
  logic all_idle;
  logic [1:0] ram_st [pms_pkg::RAM_SECTIONS];

  always_comb begin
    all_idle = (state == pms_pkg::PMS_ON) && cpu_idle && periph_idle;
    regulator_switcher_sel = switcher_enable_reg;
    system_reset = (state == pms_pkg::PMS_POR) || (state == pms_pkg::PMS_RESET);
    debug_access_port_reset = (state == pms_pkg::PMS_POR) || ((state == pms_pkg::PMS_RESET) && !keep_debug);
    core_power_down = (state == pms_pkg::PMS_OFF);
    tasks_terminate = (state == pms_pkg::PMS_OFF);
    emulated_off = (state == pms_pkg::PMS_EMU_OFF);
    fixed_latency_active = all_idle && (sub_mode == pms_pkg::PMS_SUB_FIXED);
    low_power_active = all_idle && (sub_mode == pms_pkg::PMS_SUB_LOW_POWER);
    for (int i = 0; i < pms_pkg::RAM_SECTIONS; i++) begin
      ram_st[i] = pms_pkg::pms_ram_status(state == pms_pkg::PMS_OFF,
                                          ram_power_reg[i*pms_pkg::RAM_FIELD_W +: pms_pkg::RAM_FIELD_W]);
      ram_accessible[i] = ram_st[i][1];
      ram_retained[i] = ram_st[i][0];
    end
  end

  // ==========================================================================
  // Supply-fail comparator
  pms_supply_fail u_supply_fail (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .comp_active((state == pms_pkg::PMS_ON || state == pms_pkg::PMS_EMU_OFF) && fast_clock_running),
    .cfg_enable(supply_fail_config_enable_reg),
    .supply_level(supply_level),
    .threshold(supply_fail_threshold),
    .warning_event(supply_fail_warning_event),
    .flash_write_block(flash_write_block)
  );

endmodule

// *** hw/pms_supply_fail.sv ***
// Purpose: Supply-fail comparator with warning event and flash-write block.
// Assumes: Supply level and threshold are codes on the same scale.
// Notes: Lower code means lower voltage.

`timescale 1ns/1ps

module pms_supply_fail (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Conditions
  input wire logic comp_active,
  input wire logic cfg_enable,
  input wire logic [pms_pkg::THR_W-1:0] supply_level,
  input wire logic [pms_pkg::THR_W-1:0] threshold,
  // Results
  output logic warning_event,
  output logic flash_write_block
);

  // ==========================================================================
  // Comparison
  logic below;
  logic prev_below;
  logic next_prev_below;
  logic next_warning_event;
  logic next_flash_write_block;

  // Raising the threshold above the supply, or enabling while already below,
  // both appear as a fresh rising edge of the gated condition.
  always_comb begin
    below = comp_active && cfg_enable && (supply_level < threshold);
    next_prev_below = below;
    next_warning_event = below && !prev_below;
    next_flash_write_block = below;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_below <= 1'b0;
      warning_event <= 1'b0;
      flash_write_block <= 1'b0;
    end else if (clk_en) begin
      prev_below <= next_prev_below;
      warning_event <= next_warning_event;
      flash_write_block <= next_flash_write_block;
    end
  end

endmodule

// *** testbench/pms_supervisor_assertions.sv ***
// Purpose: Port-level checks for the power mode and reset supervisor.
// Assumes: Bound to pms_supervisor and sees only its ports.
// Notes: A reset source may pre-empt an off request, so entry checks also accept a reset.

`timescale 1ns/1ps

module pms_sva (
  // Clock, reset and software writes
  input wire logic clk, rst_n, clk_en,
  input wire logic switcher_enable_wr, switcher_enable_wdata, deep_off_request_wr, deep_off_request_wdata,
  // Status inputs and threshold register
  input wire logic debug_mode, pin_detect, fast_clock_running, brownout_below,
  input wire logic [pms_pkg::THR_W-1:0] supply_level, supply_fail_threshold,
  // Registers and outputs
  input wire logic switcher_enable_reg, supply_fail_config_enable_reg, system_reset, core_power_down,
  input wire logic emulated_off, supply_fail_warning_event, flash_write_block,
  input wire logic [pms_pkg::RSN_W-1:0] reset_reason_reg,
  input wire logic [pms_pkg::RAM_SECTIONS*pms_pkg::RAM_FIELD_W-1:0] ram_power_reg,
  input wire logic [pms_pkg::RAM_SECTIONS-1:0] ram_accessible, ram_retained
);
  // ==========================================================================
  // Comparator condition, live in on and emulated off while the fast clock runs.
  wire logic below;
  assign below = !system_reset && !core_power_down && fast_clock_running && supply_fail_config_enable_reg
    && supply_level < supply_fail_threshold;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Assertions
  a_switcher_write: assert property (
    clk_en && switcher_enable_wr && !system_reset |=> switcher_enable_reg == $past(switcher_enable_wdata))
    else $error("switcher register missed a write");
  a_off_entry: assert property (
    clk_en && deep_off_request_wr && deep_off_request_wdata && !debug_mode && !system_reset && !core_power_down
    && !emulated_off |=> core_power_down || system_reset) else $error("off request did not power down");
  a_emu_entry: assert property (
    clk_en && deep_off_request_wr && deep_off_request_wdata && debug_mode && !system_reset && !core_power_down
    && !emulated_off |=> (emulated_off && !core_power_down) || system_reset) else $error("off not emulated");
  a_off_wake: assert property (
    clk_en && core_power_down && pin_detect && !brownout_below
    |=> system_reset && reset_reason_reg[pms_pkg::RSN_WAKE_OFF]) else $error("wakeup did not reset");
  a_warn_rise: assert property (
    clk_en && below && !flash_write_block |=> supply_fail_warning_event) else $error("warning event missing");
  a_flash_block: assert property (
    clk_en |=> flash_write_block == $past(below)) else $error("flash block does not follow comparator");
  a_ram_off: assert property (
    core_power_down |-> ram_accessible == 3'h0 && ram_retained == {ram_power_reg[5], ram_power_reg[3], ram_power_reg[1]})
    else $error("ram status wrong in off");
  a_brownout_hold: assert property (
    clk_en && brownout_below |=> system_reset && reset_reason_reg == pms_pkg::RSN_BROWNOUT_VALUE)
    else $error("brownout did not reset");
endmodule

bind pms_supervisor pms_sva i_sva (.*);

// *** testbench/test_pms_supervisor.sv ***
// Purpose: Self-checking bench for the power mode and reset supervisor.
// Assumes: clk_en high except for one freeze check; every software write is a one-cycle strobe.
// Notes: Strobes and write data are packed in stb and wd so one task drives every write.

`timescale 1ns/1ps

module test_pms_supervisor;
  // ==========================================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, debug_mode = 1'b0, cpu_idle = 1'b1, periph_idle = 1'b1;
  logic fast_clock_running = 1'b1, supply_valid = 1'b0, regulators_started = 1'b0;
  logic [13:0] stb = 14'h0;
  logic [15:0] wd = 16'h0;
  logic [4:0] pin_sel = 5'h0;
  logic [3:0] supply_level = 4'hf;
  logic [1:0] shadow [3] = '{2'h3, 2'h3, 2'h3};
  int bad_count = 0, n_tests = 0, cycles = 0;
  wire switcher_enable_wr = stb[0], deep_off_request_wr = stb[1], fixed_latency_task = stb[2];
  wire low_power_task = stb[3], supply_fail_config_wr = stb[4], reset_reason_clear_wr = stb[5];
  wire reset_pin_select_wr = stb[6], ram_power_wr = stb[7], pin_detect = stb[8], watchdog_timeout = stb[10];
  wire core_reset_request_bit = stb[11], control_access_port_reset_wr = stb[12], brownout_below = stb[13];
  wire switcher_enable_wdata = wd[0], deep_off_request_wdata = wd[0], supply_fail_config_enable = wd[0];
  wire reset_pin_select_connect = wd[8];
  wire [3:0] supply_fail_config_threshold = wd[7:4];
  wire [5:0] reset_reason_clear_mask = wd[5:0];
  wire [4:0] reset_pin_select_wdata = wd[4:0];
  wire [1:0] ram_power_sel = wd[15:14], ram_power_wdata = wd[1:0];
  wire [31:0] gpio_in = ~(32'(stb[9]) << pin_sel);
  logic switcher_enable_reg, supply_fail_config_enable_reg, reset_pin_connected, regulator_switcher_sel;
  logic system_reset, debug_access_port_reset, core_power_down, tasks_terminate, emulated_off;
  logic fixed_latency_active, low_power_active, supply_fail_warning_event, flash_write_block;
  logic [3:0] supply_fail_threshold;
  logic [5:0] reset_reason_reg, ram_power_reg;
  logic [4:0] reset_pin_select_reg;
  logic [2:0] ram_accessible, ram_retained;

  pms_supervisor i_dut (.*);

  initial forever #25 clk = ~clk;

  // A hang must still reach the verdict, so a cycle ceiling forces the report.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic put(input int b, input logic [15:0] d);
    @(posedge clk);
    stb <= 14'h1 << b;
    wd <= d;
    @(posedge clk);
    stb <= 14'h0;
    #1;
  endtask

  task automatic wait_on();
    int n;
    n = 0;
    while (system_reset !== 1'b0 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("system_reset", 1'b0, system_reset);
  endtask

  task automatic chk_ram(input logic off);
    logic [2:0] acc;
    logic [2:0] ret;
    for (int s = 0; s < 3; s++) begin
      acc[s] = off ? 1'b0 : shadow[s][0];
      ret[s] = off ? shadow[s][1] : shadow[s][0] | shadow[s][1];
    end
    chk("ram_power_reg", {shadow[2], shadow[1], shadow[0]}, ram_power_reg);
    chk("ram_accessible", acc, ram_accessible);
    chk("ram_retained", ret, ram_retained);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    int s;
    int lev;
    int thr;
    logic prev;
    void'($urandom(32'hc1f42ca6));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("system_reset", 1'b1, system_reset);
    @(posedge clk);
    supply_valid <= 1'b1;
    regulators_started <= 1'b1;
    wait_on();
    chk("reset_reason_reg", pms_pkg::RSN_RESET_VALUE, reset_reason_reg);
    chk("regulator_switcher_sel", 1'b0, regulator_switcher_sel);
    chk_ram(1'b0);
    put(0, 16'h1);
    chk("regulator_switcher_sel", 1'b1, regulator_switcher_sel);
    // A write strobed while the clock enable is low must not land.
    @(posedge clk);
    clk_en <= 1'b0;
    put(0, 16'h0);
    chk("regulator_switcher_sel", 1'b1, regulator_switcher_sel);
    @(posedge clk);
    clk_en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      s = $urandom_range(2);
      shadow[s] = 2'($urandom_range(3));
      put(7, {2'(s), 12'h0, shadow[s]});
      chk_ram(1'b0);
    end
    put(7, 16'hc000);
    chk_ram(1'b0);
    thr = 0;
    for (int i = 0; i < 12; i++) begin
      lev = $urandom_range(15);
      @(posedge clk);
      supply_level <= 4'(lev);
      repeat (3) @(posedge clk);
      prev = i > 0 && lev < thr;
      thr = (i == 11) ? 15 : $urandom_range(15);
      put(4, {8'h0, 4'(thr), 4'h1});
      @(posedge clk);
      #1;
      chk("supply_fail_warning_event", lev < thr && !prev, supply_fail_warning_event);
      chk("flash_write_block", lev < thr, flash_write_block);
      chk("supply_fail_threshold", thr, supply_fail_threshold);
    end
    @(posedge clk);
    supply_level <= 4'h0;
    fast_clock_running <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("flash_write_block", 1'b0, flash_write_block);
    @(posedge clk);
    fast_clock_running <= 1'b1;
    @(posedge clk);
    #1;
    chk("supply_fail_warning_event", 1'b1, supply_fail_warning_event);
    put(4, 16'h0);
    chk("supply_fail_config_enable_reg", 1'b0, supply_fail_config_enable_reg);
    chk("low_power_active", 1'b1, low_power_active);
    put(2, 16'h0);
    chk("fixed_latency_active", 1'b1, fixed_latency_active);
    @(posedge clk);
    cpu_idle <= 1'b0;
    put(3, 16'h0);
    chk("low_power_active", 1'b0, low_power_active);
    @(posedge clk);
    cpu_idle <= 1'b1;
    @(posedge clk);
    #1;
    chk("low_power_active", 1'b1, low_power_active);
    put(2, 16'h0);
    put(1, 16'h1);
    chk("core_power_down", 1'b1, core_power_down);
    chk("tasks_terminate", 1'b1, tasks_terminate);
    chk_ram(1'b1);
    put(10, 16'h0);
    chk("core_power_down", 1'b1, core_power_down);
    put(8, 16'h0);
    chk("system_reset", 1'b1, system_reset);
    chk("reset_reason_reg", pms_pkg::RSN_RESET_VALUE | 6'h08, reset_reason_reg);
    chk("debug_access_port_reset", 1'b1, debug_access_port_reset);
    wait_on();
    chk("low_power_active", 1'b1, low_power_active);
    chk("regulator_switcher_sel", 1'b0, regulator_switcher_sel);
    chk_ram(1'b0);
    @(posedge clk);
    debug_mode <= 1'b1;
    put(1, 16'h1);
    chk("emulated_off", 1'b1, emulated_off);
    chk("core_power_down", 1'b0, core_power_down);
    put(8, 16'h0);
    chk("system_reset", 1'b1, system_reset);
    chk("debug_access_port_reset", 1'b0, debug_access_port_reset);
    wait_on();
    @(posedge clk);
    debug_mode <= 1'b0;
    s = $urandom_range(31);
    pin_sel <= 5'(s);
    put(6, 16'h0100 | 16'(s));
    chk("reset_pin_connected", 1'b1, reset_pin_connected);
    chk("reset_pin_select_reg", pin_sel, reset_pin_select_reg);
    for (int k = 0; k < 4; k++) begin
      put(5, 16'h3f);
      chk("reset_reason_reg", 6'h0, reset_reason_reg);
      put(9 + k, 16'h0);
      chk("system_reset", 1'b1, system_reset);
      chk("reset_reason_reg", 6'h1 << (k == 0 ? pms_pkg::RSN_PIN : k == 1 ? pms_pkg::RSN_WATCHDOG
        : pms_pkg::RSN_SOFT), reset_reason_reg);
      wait_on();
    end
    put(13, 16'h0);
    chk("reset_reason_reg", pms_pkg::RSN_BROWNOUT_VALUE, reset_reason_reg);
    wait_on();
    report_and_stop();
  end
endmodule
